/* File: inc/cmst_pkg.sv */
// package for the message object status and identifier tag block
// assumes an 8-bit special function register port and a protocol engine beside it
//
// Overview of operation
// - received length differing from configured length sets the length warning flag
// - every received data or remote frame overwrites the object's length code
// - successful transmission of an enabled object sets its transmit done flag
// - several objects pending transmission: the lowest index is sent first
// - successful reception into an enabled object sets its receive done flag
// - one frame hitting several receive objects updates only the lowest enabled index
// - completion and error flags stay set until software clears them
// - bit error only while transmitting, except arbitration loss and any ack slot
// - more than five equal consecutive bus bits flag a stuff error
// - crc over destuffed frame mismatching received crc flags a crc error
// - bad crc delimiter, ack delimiter or end of frame flags a form error
// - no dominant ack slot on an own transmission flags an ack error
// - status bits 7..0: length, tx, rx, bit, stuff, crc, form, ack
// - standard id bits 10..3 in tag byte1, bits 2..0 in byte2 bits 7..5
// - standard layout: byte4 bit 2 remote tag, bit 0 reserved0 tag
// - reserved tag bits read undefined; software never writes ones there
// - extended id 28..21 byte1, 20..13 byte2, 12..5 byte3
// - extended byte4: id 4..0 in bits 7..3, remote bit 2, reserved 1 and 0
// - per-object extension setting selects 11-bit or 29-bit tag layout
// - status and tag registers address the object chosen by page select, 0..14
package cmst_pkg;
    localparam int CMST_NUM_OBJ = 15;
    localparam logic [7:0] CMST_ADR_PAGE = 8'hB1;
    localparam logic [7:0] CMST_ADR_STATUS = 8'hB2;
    localparam logic [7:0] CMST_ADR_CTRL = 8'hB3;
    localparam logic [7:0] CMST_ADR_TAG1 = 8'hBC;
    localparam logic [7:0] CMST_ADR_TAG2 = 8'hBD;
    localparam logic [7:0] CMST_ADR_TAG3 = 8'hBE;
    localparam logic [7:0] CMST_ADR_TAG4 = 8'hBF;
    localparam int CMST_BIT_LENW = 7;
    localparam int CMST_BIT_TXD = 6;
    localparam int CMST_BIT_RXD = 5;
    localparam int CMST_BIT_BIT_ERROR_FLAG = 4;
    localparam int CMST_BIT_STUFF_ERROR_FLAG = 3;
    localparam int CMST_BIT_CRC_ERROR_FLAG = 2;
    localparam int CMST_BIT_FORM_ERROR_FLAG = 1;
    localparam int CMST_BIT_ACK_ERROR_FLAG = 0;
    localparam int CMST_CTRL_IDE = 4;
    localparam logic [1:0] CMST_CFG_TX = 2'h1;
    localparam logic [1:0] CMST_CFG_RX = 2'h2;
    localparam logic [1:0] CMST_CFG_RXB = 2'h3;
    localparam logic [7:0] CMST_STATUS_RESET = 8'h00;
    localparam logic [7:0] CMST_CTRL_RESET = 8'h00;
    localparam logic [7:0] CMST_PAGE_RESET = 8'h00;
    localparam logic [2:0] CMST_STUFF_LIMIT = 3'h5;
endpackage

/* File: inc/cmst_evt_if.sv */
// interface carrying per-bit bus error pulses from the checker to the object store
// assumes a single clock domain
`timescale 1ns/100ps
interface cmst_evt_if;
    logic bit_err;
    logic stuff_err;
    logic crc_err;
    logic form_err;
    logic ack_err;
    modport src (output bit_err, output stuff_err, output crc_err, output form_err,
                 output ack_err);
    modport dst (input bit_err, input stuff_err, input crc_err, input form_err,
                 input ack_err);
endinterface

/* File: hw/cmst_err_check.sv */
// bus error detection per sampled bit
// assumes a protocol engine supplying field strobes and destuffed crc results
`timescale 1ns/100ps
module cmst_err_check
    import cmst_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    // bit stream
    input wire logic bit_en,
    input wire logic rx_bit,
    input wire logic tx_bit,
    input wire logic transmitting,
    input wire logic in_arbitration,
    input wire logic in_err_frame,
    input wire logic ack_slot,
    input wire logic stuff_check,
    // field checks
    input wire logic crc_done,
    input wire logic [14:0] crc_calc,
    input wire logic [14:0] crc_recv,
    input wire logic fixed_field,
    cmst_evt_if.src evt
);
    logic last_bit;
    logic [2:0] run_len;
    wire same_bit = rx_bit == last_bit;
    wire next_run_hit = stuff_check && same_bit && (run_len == CMST_STUFF_LIMIT);
    wire arb_exempt = in_arbitration && tx_bit && !rx_bit;
    wire ack_exempt = in_err_frame && ack_slot && !rx_bit;

    // ************************************************************
    // error pulses
    // ************************************************************
    assign evt.bit_err = bit_en && transmitting && (rx_bit != tx_bit) && !arb_exempt
                         && !ack_exempt && !ack_slot;
    assign evt.stuff_err = bit_en && next_run_hit;
    assign evt.crc_err = bit_en && crc_done && (crc_calc != crc_recv);
    assign evt.form_err = bit_en && fixed_field && !rx_bit;
    assign evt.ack_err = bit_en && transmitting && ack_slot && !in_err_frame
                         && rx_bit;

    // run length of equal bus bits
    always_ff @(posedge clk) begin
        if (rst) begin
            last_bit <= 1'b1;
            run_len <= 3'h1;
        end else if (bit_en) begin
            last_bit <= rx_bit;
            if (!stuff_check || !same_bit) begin
                run_len <= 3'h1;
            end else if (run_len != CMST_STUFF_LIMIT) begin
                run_len <= run_len + 3'h1;
            end
        end
    end

    a_bit_err_tx: assert property (@(posedge clk) disable iff (rst)
        (bit_en && (!transmitting || (in_arbitration && tx_bit && !rx_bit))) |-> !evt.bit_err)
        else $error("bit error outside tx or on lost arbitration");
    a_ack_err_dom: assert property (@(posedge clk) disable iff (rst)
        (bit_en && transmitting && ack_slot && !in_err_frame && !rx_bit) |-> !evt.ack_err)
        else $error("ack error despite dominant ack");
    a_form_fixed: assert property (@(posedge clk) disable iff (rst)
        evt.form_err |-> fixed_field && !rx_bit) else $error("form error without cause");
endmodule

/* File: hw/cmst_arbiter.sv */
// lowest index first selection among requesting objects
// assumes request vector is stable in the cycle it is sampled
`timescale 1ns/100ps
module cmst_arbiter
    import cmst_pkg::*;
#(
    parameter int N = CMST_NUM_OBJ
) (
    input wire logic [N-1:0] req,
    output logic any,
    output logic [3:0] idx
);
    logic [N-1:0] lower_busy;
    logic [3:0] pick [N];

    // ************************************************************
    // priority chain
    // ************************************************************
    assign lower_busy[0] = 1'b0;
    assign pick[0] = req[0] ? 4'h0 : 4'hF;
    for (genvar g = 1; g < N; g++) begin : g_chain
        assign lower_busy[g] = lower_busy[g-1] | req[g-1];
        assign pick[g] = (req[g] && !lower_busy[g]) ? 4'(g) : pick[g-1];
    end
    assign any = |req;
    assign idx = pick[N-1];
endmodule

/* File: hw/cmst_obj_status_tag.sv */
// per-object status flags and identifier tag storage, sfr port
// assumes the protocol engine gives one-cycle frame strobes on REF_CLK
`timescale 1ns/100ps
module cmst_obj_status_tag
    import cmst_pkg::*;
#(
    parameter int NUM_OBJ = CMST_NUM_OBJ
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic SRST,
    // special function register port
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    output logic SFR_HIT,
    // bit level bus view
    input wire logic BIT_EN,
    input wire logic RX_BIT,
    input wire logic TX_BIT,
    input wire logic IN_ARBITRATION,
    input wire logic IN_ERR_FRAME,
    input wire logic ACK_SLOT,
    input wire logic STUFF_CHECK,
    input wire logic CRC_DONE,
    input wire logic [14:0] CRC_CALC,
    input wire logic [14:0] CRC_RECV,
    input wire logic FIXED_FIELD,
    // frame level
    input wire logic TX_START,
    input wire logic TX_DONE,
    input wire logic RX_DONE,
    input wire logic [NUM_OBJ-1:0] RX_HIT,
    input wire logic [3:0] RX_DLC,
    input wire logic RX_RTR,
    input wire logic [28:0] RX_ID,
    // to the protocol engine
    output logic TX_PENDING,
    output logic [3:0] TX_OBJ,
    output logic [28:0] TX_ID,
    output logic TX_IDE,
    output logic TX_RTR,
    output logic [3:0] TX_DLC,
    output logic TRANSMITTING
);
    typedef enum logic [2:0] {
        CMST_IDLE = 3'b001,
        CMST_SEND = 3'b010,
        CMST_RECV = 3'b100
    } cmst_state_t;

    cmst_state_t state;
    cmst_state_t next_state;
    logic [7:0] page;
    logic [7:0] status [NUM_OBJ];
    logic [7:0] ctrl [NUM_OBJ];
    logic [7:0] tag1 [NUM_OBJ];
    logic [7:0] tag2 [NUM_OBJ];
    logic [7:0] tag3 [NUM_OBJ];
    logic [7:0] tag4 [NUM_OBJ];
    logic [3:0] cur_obj;
    logic [7:0] rdata;
    logic [NUM_OBJ-1:0] tx_req;
    logic [NUM_OBJ-1:0] rx_en;
    logic tx_any;
    logic [3:0] tx_idx;
    logic rx_any;
    logic [3:0] rx_idx;

    cmst_evt_if evt ();

    // ************************************************************
    // sub blocks
    // ************************************************************
    cmst_err_check u_err (
        .clk(REF_CLK),
        .rst(SRST),
        .bit_en(BIT_EN),
        .rx_bit(RX_BIT),
        .tx_bit(TX_BIT),
        .transmitting(TRANSMITTING),
        .in_arbitration(IN_ARBITRATION),
        .in_err_frame(IN_ERR_FRAME),
        .ack_slot(ACK_SLOT),
        .stuff_check(STUFF_CHECK),
        .crc_done(CRC_DONE),
        .crc_calc(CRC_CALC),
        .crc_recv(CRC_RECV),
        .fixed_field(FIXED_FIELD),
        .evt(evt)
    );

    cmst_arbiter #(.N(NUM_OBJ)) u_tx_arb (
        .req(tx_req),
        .any(tx_any),
        .idx(tx_idx)
    );

    cmst_arbiter #(.N(NUM_OBJ)) u_rx_arb (
        .req(RX_HIT & rx_en),
        .any(rx_any),
        .idx(rx_idx)
    );

    // ************************************************************
    // page and register decode
    // ************************************************************
    wire [3:0] sel_obj = page[7:4];
    wire sel_ok = sel_obj < 4'(NUM_OBJ);
    wire [3:0] sel = sel_ok ? sel_obj : 4'h0;
    wire hit_page = SFR_ADDR == CMST_ADR_PAGE;
    wire hit_status = SFR_ADDR == CMST_ADR_STATUS;
    wire hit_ctrl = SFR_ADDR == CMST_ADR_CTRL;
    wire hit_tag1 = SFR_ADDR == CMST_ADR_TAG1;
    wire hit_tag2 = SFR_ADDR == CMST_ADR_TAG2;
    wire hit_tag3 = SFR_ADDR == CMST_ADR_TAG3;
    wire hit_tag4 = SFR_ADDR == CMST_ADR_TAG4;
    wire hit_any = hit_page | hit_status | hit_ctrl | hit_tag1 | hit_tag2 | hit_tag3
                   | hit_tag4;
    wire wr_obj = SFR_WR && sel_ok;
    assign SFR_HIT = hit_any && (SFR_RD || SFR_WR);
    assign cur_obj = (state == CMST_SEND) ? TX_OBJ : rx_idx;

    // reserved bits read whatever was stored, which software keeps at zero
    assign rdata = hit_page ? page :
                   hit_status ? status[sel] :
                   hit_ctrl ? ctrl[sel] :
                   hit_tag1 ? tag1[sel] :
                   hit_tag2 ? tag2[sel] :
                   hit_tag3 ? tag3[sel] :
                   hit_tag4 ? tag4[sel] : 8'h00;

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            SFR_RDATA <= 8'h00;
        end else if (SFR_RD) begin
            SFR_RDATA <= rdata;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            page <= CMST_PAGE_RESET;
        end else if (SFR_WR && hit_page) begin
            page <= SFR_WDATA;
        end
    end

    // ************************************************************
    // frame sequencing
    // ************************************************************
    always_comb begin
        next_state = state;
        case (state)
            CMST_IDLE: begin
                if (TX_START && tx_any) begin
                    next_state = CMST_SEND;
                end
            end
            CMST_SEND: begin
                if (TX_DONE || evt.bit_err || evt.ack_err || evt.form_err) begin
                    next_state = CMST_IDLE;
                end
            end
            default: begin
                next_state = CMST_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            state <= CMST_IDLE;
            TX_OBJ <= 4'h0;
        end else begin
            state <= next_state;
            if (state == CMST_IDLE && TX_START && tx_any) begin
                TX_OBJ <= tx_idx;
            end
        end
    end

    assign TRANSMITTING = state == CMST_SEND;
    assign TX_PENDING = tx_any;
    assign TX_IDE = ctrl[TX_OBJ][CMST_CTRL_IDE];
    assign TX_DLC = ctrl[TX_OBJ][3:0];
    assign TX_RTR = tag4[TX_OBJ][2];
    assign TX_ID = TX_IDE ? {tag1[TX_OBJ], tag2[TX_OBJ], tag3[TX_OBJ], tag4[TX_OBJ][7:3]}
                          : {18'h00000, tag1[TX_OBJ], tag2[TX_OBJ][7:5]};

    // ************************************************************
    // per object storage
    // ************************************************************
    for (genvar g = 0; g < NUM_OBJ; g++) begin : g_obj
        wire here = sel == 4'(g) && wr_obj;
        wire is_cur = cur_obj == 4'(g);
        wire tx_ok = TRANSMITTING && TX_DONE && TX_OBJ == 4'(g);
        wire rx_ok = RX_DONE && rx_any && rx_idx == 4'(g);
        wire err_here = is_cur && (TRANSMITTING || rx_any);
        logic [7:0] ev;
        logic [7:0] next_status;
        assign tx_req[g] = ctrl[g][7:6] == CMST_CFG_TX;
        assign rx_en[g] = ctrl[g][7:6] == CMST_CFG_RX || ctrl[g][7:6] == CMST_CFG_RXB;
        assign ev[CMST_BIT_LENW] = rx_ok && RX_DLC != ctrl[g][3:0];
        assign ev[CMST_BIT_TXD] = tx_ok;
        assign ev[CMST_BIT_RXD] = rx_ok;
        assign ev[CMST_BIT_BIT_ERROR_FLAG] = err_here && evt.bit_err;
        assign ev[CMST_BIT_STUFF_ERROR_FLAG] = err_here && evt.stuff_err;
        assign ev[CMST_BIT_CRC_ERROR_FLAG] = err_here && evt.crc_err;
        assign ev[CMST_BIT_FORM_ERROR_FLAG] = err_here && evt.form_err;
        assign ev[CMST_BIT_ACK_ERROR_FLAG] = err_here && evt.ack_err;
        // set wins over a software clear in the same cycle
        assign next_status = ((here && hit_status) ? SFR_WDATA : status[g])
                             | ev;

        always_ff @(posedge REF_CLK) begin
            if (SRST) begin
                status[g] <= CMST_STATUS_RESET;
            end else begin
                status[g] <= next_status;
            end
        end

        always_ff @(posedge REF_CLK) begin
            if (SRST) begin
                ctrl[g] <= CMST_CTRL_RESET;
            end else if (rx_ok) begin
                ctrl[g] <= {2'h0, ctrl[g][5:4], RX_DLC};
            end else if (tx_ok) begin
                ctrl[g] <= {2'h0, ctrl[g][5:0]};
            end else if (here && hit_ctrl) begin
                ctrl[g] <= SFR_WDATA;
            end
        end

        // tag storage has no reset value
        always_ff @(posedge REF_CLK) begin
            if (rx_ok) begin
                if (ctrl[g][CMST_CTRL_IDE]) begin
                    tag1[g] <= RX_ID[28:21];
                    tag2[g] <= RX_ID[20:13];
                    tag3[g] <= RX_ID[12:5];
                    tag4[g] <= {RX_ID[4:0], RX_RTR, tag4[g][1:0]};
                end else begin
                    tag1[g] <= RX_ID[10:3];
                    tag2[g] <= {RX_ID[2:0], tag2[g][4:0]};
                    tag4[g] <= {tag4[g][7:3], RX_RTR, tag4[g][1:0]};
                end
            end else if (here) begin
                if (hit_tag1) begin
                    tag1[g] <= SFR_WDATA;
                end
                if (hit_tag2) begin
                    tag2[g] <= SFR_WDATA;
                end
                if (hit_tag3) begin
                    tag3[g] <= SFR_WDATA;
                end
                if (hit_tag4) begin
                    tag4[g] <= SFR_WDATA;
                end
            end
        end

        a_flag_sticky: assert property (@(posedge REF_CLK) disable iff (SRST)
            (status[g] != 8'h00 && !(here && hit_status)) |=> ((status[g] & $past(status[g]))
            == $past(status[g]))) else $error("flag dropped without clear");
        a_dlc_update: assert property (@(posedge REF_CLK) disable iff (SRST)
            rx_ok |=> ctrl[g][3:0] == $past(RX_DLC)) else $error("length not updated");
        a_lenw_set: assert property (@(posedge REF_CLK) disable iff (SRST)
            (rx_ok && RX_DLC != ctrl[g][3:0]) |=> status[g][CMST_BIT_LENW])
            else $error("length warning missing");
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_tx_done_set: assert property (@(posedge REF_CLK) disable iff (SRST)
        (TRANSMITTING && TX_DONE) |=> status[TX_OBJ][CMST_BIT_TXD])
        else $error("transmit done missing");
    a_tx_lowest: assert property (@(posedge REF_CLK) disable iff (SRST)
        (state == CMST_IDLE && TX_START && tx_any) |=> tx_req[TX_OBJ]
        && ((tx_req & ~({NUM_OBJ{1'b1}} << TX_OBJ)) == '0))
        else $error("lowest tx object skipped");
    a_rx_lowest: assert property (@(posedge REF_CLK) disable iff (SRST)
        (RX_DONE && rx_any) |-> RX_HIT[rx_idx] && rx_en[rx_idx]
        && ((RX_HIT & rx_en & ~({NUM_OBJ{1'b1}} << rx_idx)) == '0))
        else $error("lowest rx object skipped");
    a_rx_done_set: assert property (@(posedge REF_CLK) disable iff (SRST)
        (RX_DONE && rx_any) |=> status[$past(rx_idx)][CMST_BIT_RXD])
        else $error("receive done missing");
    a_set_beats_clr: assert property (@(posedge REF_CLK) disable iff (SRST)
        (TRANSMITTING && TX_DONE && SFR_WR && hit_status && sel == TX_OBJ)
        |=> status[$past(TX_OBJ)][CMST_BIT_TXD]) else $error("clear beat set");
    a_tx_pick_low: assert property (@(posedge REF_CLK) disable iff (SRST)
        tx_any |-> tx_req[tx_idx] && ((tx_req & ~({NUM_OBJ{1'b1}} << tx_idx)) == '0))
        else $error("transmit pick not lowest");

    c_tx_frame: cover property (@(posedge REF_CLK) TRANSMITTING && TX_DONE);
    c_rx_frame: cover property (@(posedge REF_CLK) RX_DONE && rx_any);
    c_ack_err: cover property (@(posedge REF_CLK) evt.ack_err);
    c_multi_hit: cover property (@(posedge REF_CLK) RX_DONE && $countones(RX_HIT & rx_en) > 1);
endmodule

/* File: verif/cmst_can_node.sv */
// bus-side model: protocol engine view of frames and sample points
// assumes its tasks are called from the bench, clocked by clk
`timescale 1ns/100ps
module cmst_can_node (
    // clock
    input wire logic clk,
    // bit level
    output logic bit_en,
    output logic rx_bit,
    output logic tx_bit,
    output logic in_arb,
    output logic in_errf,
    output logic ack_slot,
    output logic stuff_chk,
    output logic crc_done,
    output logic [14:0] crc_calc,
    output logic [14:0] crc_recv,
    output logic fixed_fld,
    // frame level
    output logic tx_start,
    output logic tx_done,
    output logic rx_done,
    output logic [14:0] rx_hit,
    output logic [3:0] rx_dlc,
    output logic rx_rtr,
    output logic [28:0] rx_id
);
    initial begin
        {bit_en, in_arb, in_errf, ack_slot, stuff_chk, crc_done, fixed_fld} = '0;
        {tx_start, tx_done, rx_done, rx_rtr, rx_bit, tx_bit} = 6'h03;
        {crc_calc, crc_recv, rx_hit, rx_dlc, rx_id} = '0;
    end
    // one sample point, f = {arb, errf, ack, stuff, fixed, crc}
    task automatic step(input logic [5:0] f, input logic tx, input logic rx);
        @(posedge clk) #1;
        {in_arb, in_errf, ack_slot, stuff_chk, fixed_fld, crc_done} = f;
        {bit_en, tx_bit, rx_bit} = {1'b1, tx, rx};
        crc_calc = 15'h2A55;
        crc_recv = f[0] ? 15'h2A54 : 15'h2A55;
        @(posedge clk) #1;
        {bit_en, in_arb, in_errf, ack_slot, stuff_chk, fixed_fld, crc_done} = '0;
        {tx_bit, rx_bit} = 2'b11;
        {crc_calc, crc_recv} = ~{crc_calc, crc_recv};
    endtask
    // one-cycle frame strobe, k = {start, done, received}
    task automatic frame(input logic [2:0] k, input logic [14:0] hit, input logic [3:0] dlc,
                         input logic rtr, input logic [28:0] id);
        @(posedge clk) #1;
        {tx_start, tx_done, rx_done} = k;
        {rx_hit, rx_dlc, rx_rtr, rx_id} = {hit, dlc, rtr, id};
        @(posedge clk) #1;
        {tx_start, tx_done, rx_done, rx_hit} = '0;
        {rx_dlc, rx_rtr, rx_id} = ~{rx_dlc, rx_rtr, rx_id};
    endtask
    task automatic pulse(input logic [2:0] k);
        frame(k, 15'h0000, 4'h0, 1'b0, 29'h0);
    endtask
endmodule

/* File: verif/cmst_obj_status_tag_test.sv */
// self-checking bench for the object status and tag block
// assumes cmst_can_node drives every protocol-side input
`timescale 1ns/100ps
module cmst_obj_status_tag_test
    import cmst_pkg::*;
;
    localparam logic [28:0] STD_ID = 29'h000005A3;
    localparam logic [28:0] EXT_ID = 29'h1ABCDE5F;
    logic ref_clk, srst, sfr_wr, sfr_rd, hit_seen, sfr_hit, tx_pending, transmitting;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [3:0] tx_obj, rx_dlc, tx_dlc;
    logic bit_en, rx_bit, tx_bit, in_arb, in_errf, ack_slot, stuff_chk, crc_done, fixed_fld;
    logic tx_start, tx_done, rx_done, rx_rtr, tx_ide, tx_rtr;
    logic [14:0] crc_calc, crc_recv, rx_hit;
    logic [28:0] rx_id, tx_id;
    logic [7:0] err_exp [7];
    int bad_count = 0;
    int num_checks = 0;

    cmst_obj_status_tag #(.NUM_OBJ(CMST_NUM_OBJ)) cmst_obj_status_tag_i (
        .REF_CLK(ref_clk), .SRST(srst), .SFR_WR(sfr_wr), .SFR_RD(sfr_rd),
        .SFR_ADDR(sfr_addr), .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata), .SFR_HIT(sfr_hit),
        .BIT_EN(bit_en), .RX_BIT(rx_bit), .TX_BIT(tx_bit), .IN_ARBITRATION(in_arb),
        .IN_ERR_FRAME(in_errf), .ACK_SLOT(ack_slot), .STUFF_CHECK(stuff_chk),
        .CRC_DONE(crc_done), .CRC_CALC(crc_calc), .CRC_RECV(crc_recv), .FIXED_FIELD(fixed_fld),
        .TX_START(tx_start), .TX_DONE(tx_done), .RX_DONE(rx_done), .RX_HIT(rx_hit),
        .RX_DLC(rx_dlc), .RX_RTR(rx_rtr), .RX_ID(rx_id), .TX_PENDING(tx_pending),
        .TX_OBJ(tx_obj), .TX_ID(tx_id), .TX_IDE(tx_ide), .TX_RTR(tx_rtr), .TX_DLC(tx_dlc),
        .TRANSMITTING(transmitting));
    cmst_can_node cmst_can_node_i (.clk(ref_clk), .bit_en, .rx_bit, .tx_bit, .in_arb,
        .in_errf, .ack_slot, .stuff_chk, .crc_done, .crc_calc, .crc_recv, .fixed_fld,
        .tx_start, .tx_done, .rx_done, .rx_hit, .rx_dlc, .rx_rtr, .rx_id);

    // ****************
    // access tasks
    // ****************
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) #1;
        {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
        @(posedge ref_clk) #1;
        sfr_wr = 1'b0;
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp,
                       input logic [7:0] m);
        @(posedge ref_clk) #1;
        {sfr_rd, sfr_addr} = {1'b1, a};
        #1 hit_seen = sfr_hit;
        @(posedge ref_clk) #1;
        sfr_rd = 1'b0;
        cmp(what, exp & m, sfr_rdata & m);
    endtask
    task automatic sel(input logic [3:0] o);
        wr(CMST_ADR_PAGE, {o, 4'h0});
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        $display("[ERR] run limit expected end seen hang");
        stop_test();
    end

    // ****************
    // scenarios
    // ****************
    initial begin
        {srst, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {1'b1, 18'h0};
        err_exp = '{8'h40, 8'h10, 8'h48, 8'h44, 8'h02, 8'h01, 8'h40};
        repeat (4) @(posedge ref_clk);
        #1 srst = 1'b0;
        sel(4'hE);
        rdc("status rst", CMST_ADR_STATUS, CMST_STATUS_RESET, 8'hFF);
        cmp("hit", 8'h01, {7'h0, hit_seen});
        rdc("ctrl rst", CMST_ADR_CTRL, CMST_CTRL_RESET, 8'hFF);
        rdc("unmapped", 8'hB0, 8'h00, 8'hFF);
        cmp("no hit", 8'h00, {7'h0, hit_seen});
        for (int o = 0; o < 15; o++) begin
            sel(o[3:0]);
            wr(CMST_ADR_TAG1, {o[3:0], 4'hA});
            wr(CMST_ADR_TAG2, {o[2:0], 5'h00});
            wr(CMST_ADR_TAG3, 8'h00);
            wr(CMST_ADR_TAG4, {5'h00, o[0], 1'b0, o[1]});
        end
        sel(4'hF);
        wr(CMST_ADR_TAG1, 8'h77);
        for (int o = 0; o < 15; o++) begin
            sel(o[3:0]);
            rdc("tag1", CMST_ADR_TAG1, {o[3:0], 4'hA}, 8'hFF);
            rdc("tag2", CMST_ADR_TAG2, {o[2:0], 5'h00}, 8'hE0);
            rdc("tag4", CMST_ADR_TAG4, {5'h00, o[0], 1'b0, o[1]}, 8'h05);
        end
        sel(4'h1);
        wr(CMST_ADR_CTRL, 8'h82);
        sel(4'h3);
        wr(CMST_ADR_CTRL, 8'h82);
        cmst_can_node_i.frame(3'b001, 15'h000A, 4'h5, 1'b0, STD_ID);
        rdc("rx other", CMST_ADR_STATUS, 8'h00, 8'hFF);
        sel(4'h1);
        rdc("rx status", CMST_ADR_STATUS, 8'hA0, 8'hFF);
        rdc("rx ctrl", CMST_ADR_CTRL, 8'h05, 8'hFF);
        rdc("rx tag1", CMST_ADR_TAG1, STD_ID[10:3], 8'hFF);
        rdc("rx tag2", CMST_ADR_TAG2, {STD_ID[2:0], 5'h00}, 8'hE0);
        rdc("rx tag4", CMST_ADR_TAG4, 8'h00, 8'h04);
        sel(4'h7);
        wr(CMST_ADR_CTRL, 8'h93);
        cmst_can_node_i.frame(3'b001, 15'h0080, 4'h3, 1'b1, EXT_ID);
        rdc("ext status", CMST_ADR_STATUS, 8'h20, 8'hFF);
        rdc("ext ctrl", CMST_ADR_CTRL, 8'h13, 8'hFF);
        rdc("ext tag1", CMST_ADR_TAG1, EXT_ID[28:21], 8'hFF);
        rdc("ext tag2", CMST_ADR_TAG2, EXT_ID[20:13], 8'hFF);
        rdc("ext tag3", CMST_ADR_TAG3, EXT_ID[12:5], 8'hFF);
        rdc("ext tag4", CMST_ADR_TAG4, {EXT_ID[4:0], 3'b100}, 8'hFC);
        sel(4'h6);
        wr(CMST_ADR_CTRL, 8'h48);
        sel(4'h4);
        wr(CMST_ADR_CTRL, 8'h48);
        cmp("pending", 8'h01, {7'h0, tx_pending});
        cmst_can_node_i.pulse(3'b100);
        cmp("tx obj", 8'h04, {4'h0, tx_obj});
        cmp("sending", 8'h01, {7'h0, transmitting});
        cmp("std id", 8'h4A, tx_id[10:3]);
        cmp("std fmt", 8'h88, {tx_id[2:0], tx_ide, tx_dlc});
        cmst_can_node_i.pulse(3'b010);
        rdc("tx4", CMST_ADR_STATUS, 8'h40, 8'hFF);
        cmst_can_node_i.pulse(3'b100);
        cmp("tx obj", 8'h06, {4'h0, tx_obj});
        cmst_can_node_i.pulse(3'b010);
        rdc("tx4 kept", CMST_ADR_STATUS, 8'h40, 8'hFF);
        sel(4'h6);
        rdc("tx6", CMST_ADR_STATUS, 8'h40, 8'hFF);
        sel(4'h7);
        wr(CMST_ADR_CTRL, 8'h53);
        cmst_can_node_i.pulse(3'b100);
        cmp("ext id", EXT_ID[28:21], tx_id[28:21]);
        cmp("ext id mid", EXT_ID[12:5], tx_id[12:5]);
        cmp("ext id lo", {EXT_ID[4:0], 3'h0}, {tx_id[4:0], 3'h0});
        cmp("ext fmt", 8'h1B, {3'h0, tx_ide, tx_rtr, tx_dlc[2:0]});
        cmst_can_node_i.pulse(3'b010);
        rdc("tx7", CMST_ADR_STATUS, 8'h60, 8'hFF);
        sel(4'h9);
        for (int k = 0; k < 7; k++) begin
            wr(CMST_ADR_CTRL, 8'h40);
            cmst_can_node_i.pulse(3'b100);
            case (k)
                0: cmst_can_node_i.step(6'b100000, 1'b1, 1'b0);
                1: cmst_can_node_i.step(6'b000000, 1'b0, 1'b1);
                2: repeat (6) cmst_can_node_i.step(6'b000100, 1'b0, 1'b0);
                3: cmst_can_node_i.step(6'b000001, 1'b1, 1'b1);
                4: cmst_can_node_i.step(6'b000010, 1'b0, 1'b0);
                5: cmst_can_node_i.step(6'b001000, 1'b1, 1'b1);
                default: cmst_can_node_i.step(6'b011000, 1'b1, 1'b0);
            endcase
            fork
                cmst_can_node_i.pulse(3'b010);
                if (k == 0) begin
                    wr(CMST_ADR_STATUS, 8'h00);
                end
            join
            rdc("err status", CMST_ADR_STATUS, err_exp[k], 8'hFF);
            wr(CMST_ADR_STATUS, 8'h00);
        end
        rdc("cleared", CMST_ADR_STATUS, 8'h00, 8'hFF);
        stop_test();
    end
endmodule
